// ### sim/adc_serial_command_decoder_bench.sv
// adc_serial_command_decoder_bench: self-checking bench of scd_top
// assumes scd_host on the link; conv_done pulses come from the bench
`timescale 1ns/1ns
module adc_serial_command_decoder_bench;
  localparam int SETTLE = 2;
  typedef struct packed {logic [4:0] addr; logic [7:0] val;} scd_row_t;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic conv_done = 1'b0;
  logic [31:0] conv_result = 32'h0;
  logic link_sclk, din, dout, strobe_n, conv_restart, standby, corr_en;
  logic [7:0] cfg0, cfg1, rx;
  logic [15:0] hpf;
  logic [23:0] ofc, fsc;
  int n_fail = 0;
  int checks_done = 0;
  int n_restart = 0;
  int n, r0;
  // reset values of every register, plus one unmapped address
  scd_row_t rows [12] = '{{5'h00, 8'hA0}, {5'h01, 8'h52}, {5'h02, 8'h08}, {5'h03, 8'h32},
    {5'h04, 8'h03}, {5'h05, 8'h00}, {5'h06, 8'h00}, {5'h07, 8'h00}, {5'h08, 8'h00},
    {5'h09, 8'h00}, {5'h0A, 8'h40}, {5'h0B, 8'h00}};
  logic [7:0] wd [4] = '{8'hFF, 8'h51, 8'h1C, 8'h45};
  always #25 ref_clk = ~ref_clk;
  always @(negedge ref_clk)
    if (conv_restart === 1'b1)
      n_restart <= n_restart + 1;
  scd_top #(.ID_NIBBLE(4'hA), .SETTLE(SETTLE)) uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .link_sclk(link_sclk), .din(din),
    .dout(dout), .result_ready_strobe_n(strobe_n), .conv_done(conv_done),
    .conv_result(conv_result), .conv_restart(conv_restart), .standby(standby),
    .corr_en(corr_en), .cfg0(cfg0), .cfg1(cfg1), .hpf(hpf), .ofc(ofc), .fsc(fsc));
  scd_host host (.ref_clk(ref_clk), .link_sclk(link_sclk), .din(din), .dout(dout));

  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %b seen %b", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    host.xfer(b, rx);
    @(negedge ref_clk);
  endtask
  task automatic conv(input logic [31:0] v);
    @(negedge ref_clk);
    conv_result = v;
    conv_done = 1'b1;
    @(negedge ref_clk);
    conv_done = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  // pulses conversions until the strobe falls, bounded
  task automatic until_ready(input logic [31:0] v, output int cnt);
    cnt = 0;
    while (strobe_n !== 1'b0 && cnt < 8)
    begin
      conv(v);
      cnt++;
    end
    if (strobe_n !== 1'b0)
    begin
      $display("unexpected strobe expected 0 seen %b", strobe_n);
      n_fail++;
      end_of_test;
    end
  endtask
  task automatic read_result(input logic [31:0] v);
    for (int k = 3; k >= 0; k--)
    begin
      cmd(8'h00);
      chk_val("result byte", 32'(v[8*k+:8]), 32'(rx));
    end
    chk_flag("strobe after read", 1'b1, strobe_n);
    cmd(8'h00);
    chk_val("tail byte", 32'h0, 32'(rx));
  endtask
  task automatic wait_reg(input logic sel, input logic [23:0] exp);
    for (int i = 0; i < 200 && (sel ? fsc : ofc) !== exp; i++)
      @(negedge ref_clk);
    chk_val(sel ? "fsc" : "ofc", 32'(exp), 32'(sel ? fsc : ofc));
  endtask

  initial
  begin
    #4000000;
    $display("unexpected run time expected end seen timeout");
    n_fail++;
    end_of_test;
  end
  initial
  begin
    repeat (6) @(negedge ref_clk);
    chk_flag("strobe in reset", 1'b1, strobe_n);
    chk_flag("corr_en in reset", 1'b1, corr_en);
    chk_val("cfg0 in reset", 32'h52, 32'(cfg0));
    chk_val("fsc in reset", 32'h400000, 32'(fsc));
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
    until_ready(32'h8123_4567, n);
    read_result(32'h8123_4567);
    // register reads of the reset values
    cmd(8'h11);
    foreach (rows[i])
    begin
      cmd({3'h1, rows[i].addr});
      cmd(8'h00);
      cmd(8'h00);
      chk_val("register read", 32'(rows[i].val), 32'(rx));
    end
    // multi-register write from the read-only id on
    r0 = n_restart;
    cmd(8'h40);
    cmd(8'h03);
    foreach (wd[k])
      cmd(wd[k]);
    chk_val("cfg0", 32'h51, 32'(cfg0));
    chk_val("cfg1", 32'h1C, 32'(cfg1));
    chk_val("hpf", 32'h0345, 32'(hpf));
    chk_flag("corr_en sinc only", 1'b0, corr_en);
    chk_val("restarts after write", 32'(r0 + 1), 32'(n_restart));
    cmd(8'h20);
    cmd(8'h03);
    foreach (wd[k])
    begin
      cmd(8'h00);
      chk_val("readback", 32'(k == 0 ? 8'hA0 : wd[k]), 32'(rx));
    end
    // soft reset, both opcode forms
    for (int k = 6; k < 8; k++)
    begin
      r0 = n_restart;
      cmd(8'(k));
      chk_val("restarts", 32'(r0 + 1), 32'(n_restart));
      chk_val("cfg0 after reset", 32'h52, 32'(cfg0));
      chk_flag("corr_en after reset", 1'b1, corr_en);
      until_ready(32'hC000_0003, n);
      chk_val("periods to strobe", 32'(SETTLE + 1), 32'(n));
      read_result(32'hC000_0003);
    end
    // resync, both opcode forms
    for (int k = 4; k < 6; k++)
    begin
      r0 = n_restart;
      cmd(8'(k));
      chk_val("restarts", 32'(r0 + 1), 32'(n_restart));
      until_ready(32'h0F00_00F1, n);
      chk_val("periods to strobe", 32'(SETTLE + 1), 32'(n));
      read_result(32'h0F00_00F1);
    end
    // standby entry and exit
    cmd(8'h02);
    chk_flag("standby", 1'b1, standby);
    conv(32'h1);
    conv(32'h1);
    chk_flag("strobe in standby", 1'b1, strobe_n);
    chk_val("cfg1 in standby", 32'h08, 32'(cfg1));
    cmd(8'h01);
    chk_flag("standby", 1'b0, standby);
    cmd(8'h03);
    chk_flag("standby", 1'b1, standby);
    cmd(8'h00);
    chk_flag("standby", 1'b0, standby);
    cmd(8'h00);
    chk_flag("standby", 1'b0, standby);
    // stopped readout, then one result on command
    cmd(8'h11);
    repeat (3) conv(32'h5A5A_A5A5);
    chk_flag("strobe stopped", 1'b1, strobe_n);
    cmd(8'h12);
    until_ready(32'h7654_3210, n);
    chk_val("periods to strobe", 32'h1, 32'(n));
    read_result(32'h7654_3210);
    conv(32'h1);
    chk_flag("strobe one per command", 1'b1, strobe_n);
    // undefined opcodes
    r0 = n_restart;
    cmd(8'h13);
    cmd(8'h9A);
    conv(32'h1);
    chk_flag("strobe after undefined", 1'b1, strobe_n);
    chk_flag("standby after undefined", 1'b0, standby);
    chk_val("restarts after undefined", 32'(r0), 32'(n_restart));
    // offset then gain calibration sequence
    cmd(8'h04);
    cmd(8'h10);
    until_ready(32'h1, n);
    cmd(8'h11);
    cmd(8'h60);
    cmd(8'h10);
    for (int k = 0; k < 16; k++)
      conv(k[0] ? 32'h0001_2200 : 32'h0001_2400);
    chk_flag("strobe during calibration", 1'b1, strobe_n);
    wait_reg(1'b0, 24'h000123);
    cmd(8'h11);
    cmd(8'h61);
    cmd(8'h10);
    repeat (16) conv(32'h4000_0000);
    wait_reg(1'b1, 24'h7FFFFF);
    end_of_test;
  end
endmodule

// ### sim/scd_host.sv
// scd_host: link controller model that clocks bytes into the decoder
// assumes ref_clk is the decoder master clock; the link clock idles low between bytes
`timescale 1ns/1ns
module scd_host (
  // master clock, used only to time the gap
  input wire logic ref_clk,
  // serial link
  output logic link_sclk,
  output logic din,
  input wire logic dout
);
  initial
  begin
    link_sclk = 1'b0;
    din = 1'b0;
  end
  // one byte msb first, 48 ns link period, dout taken at each falling edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #7;
    for (int i = 7; i >= 0; i--)
    begin
      din = tx[i];
      #24 link_sclk = 1'b1;
      #24 link_sclk = 1'b0;
      rx[i] = dout;
    end
    // released line shows the inverse of its last bit
    din = ~din;
    repeat (30) @(posedge ref_clk);
  endtask
endmodule

// ### src/scd_pkg.sv
// scd_pkg: constants and types of the serial command decoder
// assumes a host that clocks bytes msb first and keeps the inter-byte gap
// Behaviour
// - opcode 0000000x leaves standby, else ignored
// - opcode 0000001x enters standby, keeps registers
// - opcode 0000010x restarts the conversion
// - opcode 0000011x resets registers, continuous mode, restart
// - opcode 10h selects continuous readout
// - opcode 11h stops continuous readout, strobe blocked
// - register read is address byte, count byte
// - register data follows the count byte in turn
// - register write stores count+1 bytes consecutively
// - opcode 60h calibrates offset into offset register
// - opcode 61h calibrates gain into gain register
// - ready strobe returns after 64 skipped periods
// - no correction when sinc-only path selected
// - on-command result presented when data ready
// - msb first, output low after 32 bits
// - calibration averages 16 readings
package scd_pkg;
  localparam logic [7:0] OP_LEAVE_LP = 8'h00;
  localparam logic [7:0] OP_STANDBY = 8'h02;
  localparam logic [7:0] OP_RESYNC = 8'h04;
  localparam logic [7:0] OP_SOFT_RESET = 8'h06;
  localparam logic [7:0] OP_CONT = 8'h10;
  localparam logic [7:0] OP_STOP = 8'h11;
  localparam logic [7:0] OP_READ_DATA = 8'h12;
  localparam logic [2:0] OP_REGISTER_READ_CMD_PFX = 3'h1;
  localparam logic [2:0] OP_REGISTER_WRITE_CMD_PFX = 3'h2;
  localparam logic [7:0] OP_OFS_CAL = 8'h60;
  localparam logic [7:0] OP_GAIN_CAL = 8'h61;
  localparam int GAP_CYC = 24;
  localparam logic [4:0] NUM_REGS = 5'h0B;
  localparam logic [4:0] ADDR_ID = 5'h00;
  localparam logic [4:0] ADDR_CFG0 = 5'h01;
  localparam logic [4:0] ADDR_CFG1 = 5'h02;
  localparam logic [4:0] ADDR_HPF0 = 5'h03;
  localparam logic [4:0] ADDR_HPF1 = 5'h04;
  localparam logic [4:0] ADDR_OFC0 = 5'h05;
  localparam logic [4:0] ADDR_FSC0 = 5'h08;
  localparam logic [7:0] RST_CFG0 = 8'h52;
  localparam logic [7:0] RST_CFG1 = 8'h08;
  localparam logic [7:0] RST_HPF0 = 8'h32;
  localparam logic [7:0] RST_HPF1 = 8'h03;
  localparam logic [7:0] RST_FSC2 = 8'h40;
  localparam logic [1:0] FILT_SINC = 2'h1;
  localparam int SETTLE_PERIODS = 64;
  localparam logic [4:0] CAL_READINGS = 5'h10;
  localparam int CAL_SHIFT = 4;
  localparam logic [2:0] RESULT_BYTES = 3'h4;
  localparam logic [23:0] GAIN_UNITY = 24'h400000;
  localparam logic [30:0] FS_CODE = 31'h7FFFFFFF;
  localparam logic [5:0] DIV_STEPS = 6'h35;
  typedef enum logic [4:0] {
    CMD_IDLE = 5'h01,
    CMD_RD_CNT = 5'h02,
    CMD_RD_DATA = 5'h04,
    CMD_WR_CNT = 5'h08,
    CMD_WR_DATA = 5'h10
  } scd_cmd_t;
  typedef enum logic [2:0] {
    CAL_IDLE = 3'h1,
    CAL_ACC = 3'h2,
    CAL_DIV = 3'h4
  } scd_cal_t;
endpackage

// ### src/scd_top.sv
// scd_top: serial command decoder of the converter
// assumes link_sclk idles between bytes and conv_done comes from ref_clk logic
`timescale 1ns/1ns
module scd_top #(
  parameter logic [3:0] ID_NIBBLE = 4'hA, // arbitrary value
  parameter int SETTLE = scd_pkg::SETTLE_PERIODS
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // serial link
  input wire logic link_sclk,
  input wire logic din,
  output logic dout,
  output logic result_ready_strobe_n,
  // converter datapath
  input wire logic conv_done,
  input wire logic [31:0] conv_result,
  output logic conv_restart,
  output logic standby,
  output logic corr_en,
  // register contents
  output logic [7:0] cfg0,
  output logic [7:0] cfg1,
  output logic [15:0] hpf,
  output logic [23:0] ofc,
  output logic [23:0] fsc
);
  if (SETTLE < 1 || SETTLE > 127)
  begin : g_bad_settle
    $error("SETTLE out of range");
  end
  localparam logic [6:0] SETTLE_N = SETTLE[6:0];

  // link domain: byte capture and bit launch
  logic [6:0] rx_sh_q;
  logic [2:0] bit_q;
  logic [7:0] rx_byte_q;
  logic rx_tog_q;
  logic dout_q;
  logic [7:0] tx_byte_q;
  always_ff @(posedge link_sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_sh_q <= 7'h00;
      bit_q <= 3'h0;
      rx_byte_q <= 8'h00;
      rx_tog_q <= 1'b0;
      dout_q <= 1'b0;
    end
    else
    begin
      rx_sh_q <= {rx_sh_q[5:0], din};
      bit_q <= bit_q + 3'h1;
      dout_q <= tx_byte_q[3'h7 - bit_q];
      if (bit_q == 3'h7)
      begin
        rx_byte_q <= {rx_sh_q, din};
        rx_tog_q <= ~rx_tog_q;
      end
    end
  end

  // byte event crossing into ref_clk
  logic [2:0] tog_sy_q;
  logic tog_seen_q;
  logic tog_ok;
  assign tog_ok = tog_sy_q[1] == tog_sy_q[2];
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tog_sy_q <= 3'h0;
      tog_seen_q <= 1'b0;
    end
    else if (ce)
    begin
      tog_sy_q <= {tog_sy_q[1:0], rx_tog_q};
      if (tog_ok)
        tog_seen_q <= tog_sy_q[2];
    end
  end

  // command decode
  scd_pkg::scd_cmd_t st_q;
  scd_pkg::scd_cal_t cal_q;
  logic [4:0] addr_q;
  logic [4:0] cnt_q;
  logic [7:0] b;
  logic ev, idle_ev, op_leave, op_stby, op_sync, op_rst, op_cont, op_stop;
  logic op_read, op_register_read_cmd, op_register_write_cmd, op_ofs, op_gain, wr_en, wr_done, present;
  logic mode_cont_q, standby_q, pend_q, restart_q, result_ready_strobe_n_q, corr_en_q;
  logic [6:0] skip_q;
  logic [7:0] regs_q [1:10];

  function automatic logic op_is(input logic [7:0] v, input logic [7:0] op);
    return v[7:1] == op[7:1];
  endfunction

  function automatic logic [7:0] reg_rst(input int i);
    case (i)
      1: return scd_pkg::RST_CFG0;
      2: return scd_pkg::RST_CFG1;
      3: return scd_pkg::RST_HPF0;
      4: return scd_pkg::RST_HPF1;
      10: return scd_pkg::RST_FSC2;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] reg_rd(input logic [4:0] a);
    if (a == scd_pkg::ADDR_ID)
      return {ID_NIBBLE, 4'h0};
    else if (a < scd_pkg::NUM_REGS)
      return regs_q[a];
    else
      return 8'h00;
  endfunction

  assign b = rx_byte_q;
  assign ev = ce && tog_ok && (tog_sy_q[2] != tog_seen_q);
  assign idle_ev = ev && st_q == scd_pkg::CMD_IDLE;
  assign op_leave = idle_ev && op_is(b, scd_pkg::OP_LEAVE_LP);
  assign op_stby = idle_ev && op_is(b, scd_pkg::OP_STANDBY);
  assign op_sync = idle_ev && op_is(b, scd_pkg::OP_RESYNC);
  assign op_rst = idle_ev && op_is(b, scd_pkg::OP_SOFT_RESET);
  assign op_cont = idle_ev && b == scd_pkg::OP_CONT;
  assign op_stop = idle_ev && b == scd_pkg::OP_STOP;
  assign op_read = idle_ev && b == scd_pkg::OP_READ_DATA;
  assign op_register_read_cmd = idle_ev && b[7:5] == scd_pkg::OP_REGISTER_READ_CMD_PFX;
  assign op_register_write_cmd = idle_ev && b[7:5] == scd_pkg::OP_REGISTER_WRITE_CMD_PFX;
  assign op_ofs = idle_ev && b == scd_pkg::OP_OFS_CAL;
  assign op_gain = idle_ev && b == scd_pkg::OP_GAIN_CAL;
  assign wr_en = ev && st_q == scd_pkg::CMD_WR_DATA;
  assign wr_done = wr_en && cnt_q == 5'h00;
  assign present = ce && conv_done && !standby_q && skip_q == 7'h00
                   && cal_q == scd_pkg::CAL_IDLE && (mode_cont_q || pend_q) && !op_stop;

  // multi-byte command sequencing
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= scd_pkg::CMD_IDLE;
      addr_q <= 5'h00;
      cnt_q <= 5'h00;
    end
    else if (ev)
    begin
      unique case (st_q)
        scd_pkg::CMD_IDLE:
        begin
          addr_q <= b[4:0];
          if (op_register_read_cmd)
            st_q <= scd_pkg::CMD_RD_CNT;
          else if (op_register_write_cmd)
            st_q <= scd_pkg::CMD_WR_CNT;
        end
        scd_pkg::CMD_RD_CNT:
        begin
          cnt_q <= b[4:0];
          st_q <= scd_pkg::CMD_RD_DATA;
        end
        scd_pkg::CMD_WR_CNT:
        begin
          cnt_q <= b[4:0];
          st_q <= scd_pkg::CMD_WR_DATA;
        end
        default:
        begin
          addr_q <= addr_q + 5'h01;
          cnt_q <= cnt_q - 5'h01;
          if (cnt_q == 5'h00)
            st_q <= scd_pkg::CMD_IDLE;
        end
      endcase
    end
  end

  // modes, standby, restart and settling
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_cont_q <= 1'b1;
      standby_q <= 1'b0;
      pend_q <= 1'b0;
      restart_q <= 1'b0;
      skip_q <= 7'h00;
    end
    else if (ce)
    begin
      restart_q <= op_sync || op_rst || wr_done;
      if (op_sync || op_rst || wr_done)
        skip_q <= SETTLE_N;
      else if (conv_done && skip_q != 7'h00)
        skip_q <= skip_q - 7'h01;
      if (op_stby)
        standby_q <= 1'b1;
      else if (op_leave || op_rst)
        standby_q <= 1'b0;
      if (op_rst || op_cont)
        mode_cont_q <= 1'b1;
      else if (op_stop)
        mode_cont_q <= 1'b0;
      if (op_read && !mode_cont_q)
        pend_q <= 1'b1;
      else if (present || op_rst)
        pend_q <= 1'b0;
    end
  end

  // ready strobe
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      result_ready_strobe_n_q <= 1'b1;
    else if (present)
      result_ready_strobe_n_q <= 1'b0;
    else if (ev)
      result_ready_strobe_n_q <= 1'b1;
  end

  // transmit byte for the link
  logic [23:0] res_q;
  logic [2:0] left_q;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_byte_q <= 8'h00;
      res_q <= 24'h000000;
      left_q <= 3'h0;
    end
    else if (present)
    begin
      tx_byte_q <= conv_result[31:24];
      res_q <= conv_result[23:0];
      left_q <= scd_pkg::RESULT_BYTES - 3'h1;
    end
    else if (ev)
    begin
      if (st_q == scd_pkg::CMD_RD_CNT)
        tx_byte_q <= reg_rd(addr_q);
      else if (st_q == scd_pkg::CMD_RD_DATA)
        tx_byte_q <= (cnt_q == 5'h00) ? 8'h00 : reg_rd(addr_q + 5'h01);
      else if (left_q != 3'h0)
      begin
        tx_byte_q <= res_q[23:16];
        res_q <= {res_q[15:0], 8'h00};
        left_q <= left_q - 3'h1;
      end
      else
        tx_byte_q <= 8'h00;
    end
  end

  // self calibration
  logic [4:0] cal_n_q;
  logic cal_gain_q, cal_wr_q;
  logic [35:0] acc_q;
  logic [35:0] acc_nx;
  logic [31:0] div_q;
  logic [52:0] dvd_q;
  logic [32:0] rem_q;
  logic [32:0] rem_nx;
  logic [23:0] quo_q;
  logic [23:0] cal_val_q;
  logic [5:0] div_n_q;
  logic rem_ge;
  assign acc_nx = acc_q + {{4{conv_result[31]}}, conv_result};
  assign rem_nx = {rem_q[31:0], dvd_q[52]};
  assign rem_ge = rem_nx >= {1'b0, div_q};
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cal_q <= scd_pkg::CAL_IDLE;
      cal_n_q <= 5'h00;
      cal_gain_q <= 1'b0;
      cal_wr_q <= 1'b0;
      acc_q <= 36'h000000000;
      div_q <= 32'h00000000;
      dvd_q <= 53'h0;
      rem_q <= 33'h0;
      quo_q <= 24'h000000;
      cal_val_q <= 24'h000000;
      div_n_q <= 6'h00;
    end
    else if (ce)
    begin
      cal_wr_q <= 1'b0;
      unique case (cal_q)
        scd_pkg::CAL_IDLE:
        begin
          if (op_ofs || op_gain)
          begin
            cal_q <= scd_pkg::CAL_ACC;
            cal_gain_q <= op_gain;
            cal_n_q <= 5'h00;
            acc_q <= 36'h000000000;
          end
        end
        scd_pkg::CAL_ACC:
        begin
          if (op_rst)
            cal_q <= scd_pkg::CAL_IDLE;
          else if (conv_done)
          begin
            acc_q <= acc_nx;
            cal_n_q <= cal_n_q + 5'h01;
            if (cal_n_q == scd_pkg::CAL_READINGS - 5'h01)
            begin
              div_q <= acc_nx[scd_pkg::CAL_SHIFT +: 32];
              if (!cal_gain_q)
              begin
                cal_val_q <= acc_nx[scd_pkg::CAL_SHIFT + 8 +: 24];
                cal_wr_q <= 1'b1;
                cal_q <= scd_pkg::CAL_IDLE;
              end
              else if (acc_nx[35] || acc_nx[scd_pkg::CAL_SHIFT +: 32] == 32'h00000000)
              begin
                cal_val_q <= scd_pkg::GAIN_UNITY;
                cal_wr_q <= 1'b1;
                cal_q <= scd_pkg::CAL_IDLE;
              end
              else
              begin
                dvd_q <= {scd_pkg::FS_CODE, 22'h000000};
                rem_q <= 33'h0;
                quo_q <= 24'h000000;
                div_n_q <= scd_pkg::DIV_STEPS;
                cal_q <= scd_pkg::CAL_DIV;
              end
            end
          end
        end
        scd_pkg::CAL_DIV:
        begin
          dvd_q <= {dvd_q[51:0], 1'b0};
          rem_q <= rem_ge ? rem_nx - {1'b0, div_q} : rem_nx;
          quo_q <= {quo_q[22:0], rem_ge};
          div_n_q <= div_n_q - 6'h01;
          if (div_n_q == 6'h01)
          begin
            cal_val_q <= {quo_q[22:0], rem_ge};
            cal_wr_q <= 1'b1;
            cal_q <= scd_pkg::CAL_IDLE;
          end
        end
        default:
          cal_q <= scd_pkg::CAL_IDLE;
      endcase
    end
  end

  // register file
  logic [4:0] cal_base;
  assign cal_base = cal_gain_q ? scd_pkg::ADDR_FSC0 : scd_pkg::ADDR_OFC0;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 1; i <= 10; i++)
        regs_q[i] <= reg_rst(i);
    end
    else if (ce)
    begin
      if (op_rst)
      begin
        for (int i = 1; i <= 10; i++)
          regs_q[i] <= reg_rst(i);
      end
      else if (wr_en && addr_q != scd_pkg::ADDR_ID && addr_q < scd_pkg::NUM_REGS)
        regs_q[addr_q] <= b;
      else if (cal_wr_q)
      begin
        regs_q[cal_base] <= cal_val_q[7:0];
        regs_q[cal_base + 5'h01] <= cal_val_q[15:8];
        regs_q[cal_base + 5'h02] <= cal_val_q[23:16];
      end
    end
  end

  // correction gating
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      corr_en_q <= 1'b1;
    else if (ce)
      corr_en_q <= regs_q[1][1:0] != scd_pkg::FILT_SINC;
  end

  assign dout = dout_q;
  assign result_ready_strobe_n = result_ready_strobe_n_q;
  assign conv_restart = restart_q;
  assign standby = standby_q;
  assign corr_en = corr_en_q;
  assign cfg0 = regs_q[1];
  assign cfg1 = regs_q[2];
  assign hpf = {regs_q[4], regs_q[3]};
  assign ofc = {regs_q[7], regs_q[6], regs_q[5]};
  assign fsc = {regs_q[10], regs_q[9], regs_q[8]};

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_leave;
    op_leave |=> !standby_q;
  endproperty
  a_leave: assert property (p_leave) else $error("standby not left");
  property p_stby_hold;
    $fell(standby_q) |-> $past(op_leave || op_rst);
  endproperty
  a_stby_hold: assert property (p_stby_hold) else $error("standby left alone");
  property p_sync;
    op_sync |=> conv_restart && skip_q == SETTLE_N;
  endproperty
  a_sync: assert property (p_sync) else $error("resync missed");
  property p_rst;
    op_rst |=> mode_cont_q && cfg0 == scd_pkg::RST_CFG0 && conv_restart;
  endproperty
  a_rst: assert property (p_rst) else $error("soft reset incomplete");
  property p_stop;
    op_stop ##1 (!pend_q && !ev) |=> result_ready_strobe_n;
  endproperty
  a_stop: assert property (p_stop) else $error("strobe not blocked");
  property p_present;
    present |=> !result_ready_strobe_n && tx_byte_q == $past(conv_result[31:24]);
  endproperty
  a_present: assert property (p_present) else $error("result not shown");
  property p_register_read_cmd;
    ev && st_q == scd_pkg::CMD_RD_CNT && !present |=> tx_byte_q == reg_rd($past(addr_q));
  endproperty
  a_register_read_cmd: assert property (p_register_read_cmd) else $error("register read wrong");
  property p_register_write_cmd;
    wr_en && !op_rst && addr_q == scd_pkg::ADDR_CFG1 |=> cfg1 == $past(b);
  endproperty
  a_register_write_cmd: assert property (p_register_write_cmd) else $error("register write lost");
  property p_unknown;
    idle_ev && !(op_leave || op_stby || op_sync || op_rst || op_cont || op_stop
      || op_register_read_cmd || op_register_write_cmd) |=> $stable(mode_cont_q) && st_q == scd_pkg::CMD_IDLE;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown opcode acted");
  property p_sinc;
    ce && cfg0[1:0] == scd_pkg::FILT_SINC |=> !corr_en;
  endproperty
  a_sinc: assert property (p_sinc) else $error("correction in sinc mode");
  c_register_read_cmd: cover property (ev && st_q == scd_pkg::CMD_RD_DATA && cnt_q == 5'h00);
  c_cal: cover property (cal_wr_q && cal_gain_q);
  c_cmd_read: cover property (pend_q && present);
endmodule
